//--- hdl/slw_pkg.sv
package slw_pkg;

  // array geometry
  localparam int ADDR_W     = 10;
  localparam int BYTE_W     = 9;
  localparam int NUM_BYTES  = 4;
  localparam int DATA_W     = BYTE_W * NUM_BYTES;
  localparam int BURST_W    = 2;

  // sleep entry and exit delay, in clock cycles
  localparam int SLEEP_DLY  = 2;

  // clock figures
  localparam int CLK_PERIOD_NS = 40;

  // command of one registered cycle
  typedef enum logic [1:0] {
    SLW_OP_DESEL,
    SLW_OP_READ,
    SLW_OP_WRITE
  } slw_op_t;

  // one stage of the data pipeline
  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [ADDR_W-1:0]       addr;
    logic [NUM_BYTES-1:0]    ben;
  } slw_stage_t;

  localparam slw_stage_t STAGE_IDLE = '{valid: 1'b0, write: 1'b0, addr: '0, ben: '0};

endpackage

//--- hdl/slw_burst_cnt.sv
`timescale 1ns/1ps
module slw_burst_cnt
  import slw_pkg::*;
#(
  parameter int W = BURST_W
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // control
  input  wire logic         load_i,
  input  wire logic         step_i,
  input  wire logic         interleave_i,
  input  wire logic [W-1:0] base_i,
  // current low address bits
  output logic [W-1:0]      addr_o
);

  logic [W-1:0] base_reg;
  logic [W-1:0] step_reg;

  // load sets origin; the load itself uses the pin address, so the first
  // continue must already see the next position, not repeat the loaded one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg <= '0;
      step_reg <= '0;
    end else if (load_i) begin
      base_reg <= base_i;
      step_reg <= W'(1);
    end else if (step_i) begin
      step_reg <= step_reg + W'(1);
    end
  end

  // linear adds, interleaved xors; both wrap after four
  always_comb begin
    if (interleave_i) begin
      addr_o = base_reg ^ step_reg;
    end else begin
      addr_o = base_reg + step_reg;
    end
  end

endmodule

//--- hdl/slw_sleep_ctl.sv
`timescale 1ns/1ps
module slw_sleep_ctl
  import slw_pkg::*;
#(
  parameter int DLY = SLEEP_DLY
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // request
  input  wire logic sleep_request_i,
  // state
  output logic      asleep_o
);

  logic [DLY-1:0] hist_reg;

  // request delayed by DLY cycles on both edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= {hist_reg[DLY-2:0], sleep_request_i};
    end
  end

  assign asleep_o = hist_reg[DLY-1];

endmodule

//--- hdl/slw_sram_core.sv
`timescale 1ns/1ps
module slw_sram_core
  import slw_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int NB = NUM_BYTES,
  parameter int BW = BYTE_W
) (
  // clock and reset
  input  wire logic             CLK_I,
  input  wire logic             RST_N_I,
  // command
  input  wire logic             CLOCK_GATE_N_I,
  input  wire logic             CHIP_SELECT_ONE_N_I,
  input  wire logic             CHIP_SELECT_TWO_I,
  input  wire logic             CHIP_SELECT_THREE_N_I,
  input  wire logic             ADVANCE_LOAD_I,
  input  wire logic             WRITE_N_I,
  input  wire logic [NB-1:0]    BYTE_STROBE_N_I,
  input  wire logic [AW-1:0]    ADDR_I,
  // asynchronous controls
  input  wire logic             OUTPUT_ENABLE_N_I,
  input  wire logic             SLEEP_REQUEST_I,
  // static configuration
  input  wire logic             FLOW_THROUGH_SELECT_N_I,
  input  wire logic             BURST_ORDER_SELECT_I,
  // data bus
  input  wire logic [NB*BW-1:0] DQ_I,
  output logic [NB*BW-1:0]      DQ_O,
  output logic                  DQ_OE_O
);

  localparam int DW = NB * BW;

  logic [DW-1:0]     mem [0:(1<<AW)-1];
  logic              asleep;
  logic              run;
  logic              flow;
  logic              sel;
  logic              load;
  logic              cont;
  logic              cmd_valid;
  logic [AW-1:0]     cmd_addr;
  logic [BURST_W-1:0] burst_addr;
  logic              oe_now;
  slw_op_t           op_reg;
  slw_op_t           op_now;
  slw_stage_t        cmd_now;
  slw_stage_t        s1_reg;
  slw_stage_t        s2_reg;
  slw_stage_t        wr_stage;
  logic [AW-BURST_W-1:0] hi_addr_reg;
  logic [NB-1:0]     ben_reg;
  logic [DW-1:0]     rd_word;
  logic [DW-1:0]     out_reg;
  logic              out_valid_reg;
  logic              out_write_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // sleep blocks every edge, like a held clock gate
  assign run  = !CLOCK_GATE_N_I && !asleep;
  assign flow = !FLOW_THROUGH_SELECT_N_I;
  assign sel  = !CHIP_SELECT_ONE_N_I && CHIP_SELECT_TWO_I && !CHIP_SELECT_THREE_N_I;
  assign load = run && !ADVANCE_LOAD_I;
  assign cont = run && ADVANCE_LOAD_I;

  always_comb begin
    if (!sel) begin
      op_now = SLW_OP_DESEL;
    end else if (WRITE_N_I) begin
      op_now = SLW_OP_READ;
    end else begin
      op_now = SLW_OP_WRITE;
    end
  end

  // continue repeats the type of the last load
  assign cmd_valid = load ? (op_now != SLW_OP_DESEL) : (op_reg != SLW_OP_DESEL);

  slw_sleep_ctl #(
    .DLY (SLEEP_DLY)
  ) u_sleep (
    .clk_i           (CLK_I),
    .rst_n_i         (RST_N_I),
    .sleep_request_i (SLEEP_REQUEST_I),
    .asleep_o        (asleep)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address

  slw_burst_cnt #(
    .W (BURST_W)
  ) u_burst (
    .clk_i        (CLK_I),
    .rst_n_i      (RST_N_I),
    .load_i       (load),
    .step_i       (cont),
    .interleave_i (BURST_ORDER_SELECT_I),
    .base_i       (ADDR_I[BURST_W-1:0]),
    .addr_o       (burst_addr)
  );

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      op_reg      <= SLW_OP_DESEL;
      hi_addr_reg <= '0;
    end else if (load) begin
      op_reg      <= op_now;
      hi_addr_reg <= ADDR_I[AW-1:BURST_W];
    end
  end

  // continue address: held upper bits plus the burst position
  always_comb begin
    cmd_addr      = {hi_addr_reg, burst_addr};
    cmd_now       = STAGE_IDLE;
    cmd_now.valid = cmd_valid;
    cmd_now.write = load ? (op_now == SLW_OP_WRITE) : (op_reg == SLW_OP_WRITE);
    cmd_now.ben   = ~BYTE_STROBE_N_I;
    if (load) begin
      cmd_now.addr = ADDR_I;
    end else begin
      cmd_now.addr = cmd_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command pipeline

  // stages advance only on ungated edges
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1_reg <= STAGE_IDLE;
      s2_reg <= STAGE_IDLE;
    end else if (run) begin
      s1_reg <= cmd_now;
      s2_reg <= s1_reg;
    end
  end

  // late write: data one edge later in flow mode, two in pipelined
  assign wr_stage = flow ? s1_reg : s2_reg;

  always_ff @(posedge CLK_I) begin
    if (run && wr_stage.valid && wr_stage.write) begin
      for (int b = 0; b < NB; b++) begin
        if (wr_stage.ben[b]) begin
          mem[wr_stage.addr][b*BW +: BW] <= DQ_I[b*BW +: BW];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  assign rd_word = mem[s1_reg.addr];

  // output register loads at the edge after the read was registered
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
      out_write_reg <= 1'b0;
    end else if (run) begin
      out_reg       <= rd_word;
      out_valid_reg <= s1_reg.valid;
      out_write_reg <= s1_reg.write;
    end
  end

  // flow mode bypasses the output register
  always_comb begin
    if (flow) begin
      DQ_O   = rd_word;
      oe_now = s1_reg.valid && !s1_reg.write && !CLOCK_GATE_N_I;
    end else begin
      DQ_O   = out_reg;
      oe_now = out_valid_reg && !out_write_reg;
    end
  end

  // write cycles, oe high and sleep all float the bus
  assign DQ_OE_O = oe_now && !OUTPUT_ENABLE_N_I && !asleep;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence read_load_s;
    load && sel && WRITE_N_I;
  endsequence

  sequence write_load_s;
    load && sel && !WRITE_N_I && !(&BYTE_STROBE_N_I);
  endsequence

  pipe_read_two_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (read_load_s and !flow) ##1 run ##1 (!OUTPUT_ENABLE_N_I && !asleep) |-> DQ_OE_O)
    else $error("pipelined read not driven two edges later");

  flow_read_one_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (read_load_s and flow) ##1 (!CLOCK_GATE_N_I && !OUTPUT_ENABLE_N_I && !asleep) |-> DQ_OE_O)
    else $error("flow read not driven next cycle");

  desel_float_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (load && !sel) ##1 (run && ADVANCE_LOAD_I) [*2] |-> !DQ_OE_O)
    else $error("bus driven after deselect");

  oe_float_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    OUTPUT_ENABLE_N_I |-> !DQ_OE_O)
    else $error("bus driven with output enable high");

  write_float_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (write_load_s and flow) ##1 1'b1 |-> !DQ_OE_O)
    else $error("bus driven in write data cycle");

  gate_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CLOCK_GATE_N_I |=> ($stable(s1_reg) && $stable(op_reg) && $stable(burst_addr)))
    else $error("state moved on gated edge");

  sleep_float_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    SLEEP_REQUEST_I [*2] |=> !DQ_OE_O)
    else $error("bus driven in sleep");

  wake_delay_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $fell(SLEEP_REQUEST_I) |-> asleep ##1 asleep ##1 !asleep)
    else $error("sleep exit not two cycles");

  burst_step_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (cont && !BURST_ORDER_SELECT_I) |=> burst_addr == $past(burst_addr) + 2'h1)
    else $error("linear burst did not step");

endmodule

//--- sim/slw_ctl_model.sv
`timescale 1ns/1ps
module slw_ctl_model
  import slw_pkg::*;
(
  // clock and pacing
  input  wire logic              clk_i,
  input  wire logic              gate_n_i,
  input  wire logic              flow_n_i,
  // write data request
  input  wire logic              push_i,
  input  wire logic [DATA_W-1:0] data_i,
  // data toward the ram
  output logic [DATA_W-1:0]      dq_o
);
  logic [DATA_W-1:0] slot_d [2];
  logic [1:0]        slot_v = '0;

  ////////////////////////////////////////
  // late write pipe; moves on every edge the clock gate lets through, sleep included, so gate stalls hold data
  always @(posedge clk_i) begin
    if (!gate_n_i) begin
      slot_d[0] <= flow_n_i ? slot_d[1] : data_i;
      slot_v[0] <= flow_n_i ? slot_v[1] : push_i;
      slot_d[1] <= data_i;
      slot_v[1] <= push_i && flow_n_i;
    end
  end

  ////////////////////////////////////////
  // data not due is never left standing: inverse keeps a stale match out
  initial dq_o = '0;
  always @(negedge clk_i) begin
    dq_o <= slot_v[0] ? slot_d[0] : ~dq_o;
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import slw_pkg::*;
;
  localparam logic [2:0] ACT = 3'b010;
  localparam logic [2:0] DES = 3'b110;
  localparam logic [2:0] OFF [3] = '{3'b110, 3'b000, 3'b011};
  logic                 clk, rst_n, gate_n, advance_load, wr_n, oe_n, zz, ft_n, burst_order_select, push, dq_oe;
  logic                 gate_req = 0, oe_req = 0, zz_req = 0;
  logic [2:0]           cs;
  logic [NUM_BYTES-1:0] be_n;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wd, dq_i, dq_o;
  int                   mismatches = 0, check_count = 0, lat;

  slw_sram_core DUT (
    .CLK_I(clk), .RST_N_I(rst_n), .CLOCK_GATE_N_I(gate_n), .CHIP_SELECT_ONE_N_I(cs[2]),
    .CHIP_SELECT_TWO_I(cs[1]), .CHIP_SELECT_THREE_N_I(cs[0]), .ADVANCE_LOAD_I(advance_load),
    .WRITE_N_I(wr_n), .BYTE_STROBE_N_I(be_n), .ADDR_I(addr), .OUTPUT_ENABLE_N_I(oe_n),
    .SLEEP_REQUEST_I(zz), .FLOW_THROUGH_SELECT_N_I(ft_n), .BURST_ORDER_SELECT_I(burst_order_select),
    .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_O(dq_oe));
  slw_ctl_model partner (
    .clk_i(clk), .gate_n_i(gate_n), .flow_n_i(ft_n), .push_i(push), .data_i(wd), .dq_o(dq_i));

  initial begin
    clk = 0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  ////////////////////////////////////////
  // address-derived pattern from bits 8:0, so words differ where those address bits differ
  function automatic logic [DATA_W-1:0] dat(input logic [ADDR_W-1:0] a);
    return {4{a[8:0] ^ 9'h155}};
  endfunction
  function automatic logic [ADDR_W-1:0] nx(input logic [ADDR_W-1:0] a, input int k);
    return {a[9:2], burst_order_select ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction
  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic oe_is(input logic e);
    chk(DATA_W'(dq_oe), DATA_W'(e));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one ram cycle, applied at the falling edge
  task automatic drv(input logic [2:0] c, input logic ld, w, input logic [3:0] b,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    cs = c;
    advance_load = !ld;
    wr_n = !w;
    be_n = b;
    addr = a;
    wd = d;
    push = w;
    gate_n = gate_req;
    oe_n = oe_req;
    zz = zz_req;
    #1;
  endtask
  task automatic do_reset(input logic f, o);
    rst_n = 0;
    ft_n = f;
    burst_order_select = o;
    lat = f ? 2 : 1;
    repeat (12) @(negedge clk);
    oe_is(0);
    rst_n = 1;
  endtask
  task automatic wr1(input logic [3:0] b, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    drv(ACT, 1, 1, b, a, d);
    repeat (lat + 1) drv(DES, 1, 0, 4'hf, a, '0);
  endtask
  task automatic rd1(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    drv(ACT, 1, 0, 4'hf, a, '0);
    repeat (lat) drv(DES, 1, 0, 4'hf, a, '0);
    chk(dq_o, e);
  endtask
  // four-beat burst, then one deselect load and lat - 1 continues to drain the pipe
  task automatic burst(input logic w, input logic [ADDR_W-1:0] a);
    for (int k = 0; k < 4 + lat; k++) begin
      drv(k < 4 ? ACT : DES, k == 0 || k == 4, w && k < 4, 4'h0, a, dat(nx(a, k)));
      if (k >= lat) oe_is(!w);
      if (!w && k >= lat) chk(dq_o, dat(nx(a, k - lat)));
    end
  endtask

  ////////////////////////////////////////
  task automatic t_rw;
    burst(1, 10'h004);
    burst(0, 10'h006);
    burst(0, 10'h005);
    $display("read write burst test done");
  endtask
  task automatic t_oe;
    oe_req = 1;
    drv(ACT, 1, 0, 4'hf, 10'h005, '0);
    repeat (2) begin
      drv(ACT, 0, 0, 4'hf, 10'h005, '0);
      oe_is(0);
    end
    oe_req = 0;
    drv(ACT, 0, 0, 4'hf, 10'h005, '0);
    chk(dq_o, dat(nx(10'h005, 3 - lat)));
    repeat (lat) drv(DES, 1, 0, 4'hf, 10'h005, '0);
    $display("output enable test done");
  endtask
  task automatic t_gate;
    drv(ACT, 1, 0, 4'hf, 10'h004, '0);
    drv(ACT, 0, 0, 4'hf, 10'h004, '0);
    gate_req = 1;
    repeat (3) begin
      drv(ACT, 0, 0, 4'hf, 10'h004, '0);
      chk(dq_o, dat(10'h004));
      oe_is(1);
    end
    gate_req = 0;
    repeat (2) drv(ACT, 0, 0, 4'hf, 10'h004, '0);
    chk(dq_o, dat(10'h005));
    repeat (lat) drv(DES, 1, 0, 4'hf, 10'h004, '0);
    $display("clock gate test done");
  endtask
  task automatic t_sleep;
    drv(ACT, 1, 0, 4'hf, 10'h004, '0);
    repeat (2) drv(ACT, 0, 0, 4'hf, 10'h004, '0);
    oe_is(1);
    zz_req = 1;
    repeat (2) drv(ACT, 0, 0, 4'hf, 10'h004, '0);
    oe_is(1);
    repeat (2) drv(ACT, 0, 0, 4'hf, 10'h004, '0);
    oe_is(0);
    drv(ACT, 1, 1, 4'h0, 10'h004, '0);
    zz_req = 0;
    repeat (3) drv(DES, 1, 0, 4'hf, 10'h004, '0);
    rd1(10'h004, dat(10'h004));
    $display("sleep test done");
  endtask
  task automatic t_bytes;
    for (int b = 0; b < 4; b++) begin
      wr1(~(4'h1 << b), 10'(4 + b), '0);
      rd1(10'(4 + b), dat(10'(4 + b)) & ~(36'h1ff << 9 * b));
    end
    wr1(4'hf, 10'h004, '0);
    rd1(10'h004, dat(10'h004) & ~36'h1ff);
    $display("byte strobe test done");
  endtask
  task automatic t_desel;
    for (int i = 0; i < 3; i++) begin
      drv(OFF[i], 1, 0, 4'hf, 10'h006, '0);
      repeat (3) begin
        drv(ACT, 0, 0, 4'hf, 10'h006, '0);
        oe_is(0);
      end
    end
    $display("deselect test done");
  endtask

  ////////////////////////////////////////
  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #(CLK_PERIOD_NS * 4000);
    mismatches++;
    print_verdict;
  end
  initial begin
    rst_n = 0;
    cs = DES;
    advance_load = 0;
    wr_n = 1;
    be_n = '1;
    addr = '0;
    wd = '0;
    push = 0;
    gate_n = 0;
    oe_n = 0;
    zz = 0;
    do_reset(1, 0);
    t_rw;
    t_oe;
    t_gate;
    t_sleep;
    t_bytes;
    t_desel;
    do_reset(0, 1);
    t_rw;
    t_oe;
    t_bytes;
    t_desel;
    print_verdict;
  end
endmodule
